//--- dbm_byte_mask_inversion.sv
// dbm_byte_mask_inversion.sv: per-byte mask / inversion path of the DRAM data interface
// assumes: link pins come from another clock domain; core side and APB run on SYS_CLK
//
// Behaviour
// - masking applies to writes only; inversion to writes and reads; lanes independent
// - io config bit 7 set enables inversion of write and masked write data
// - io config bit 6 enables inversion of read data
// - misc control bit 5 clear enables masking, set disables it
// - one two-way double-rate mask/invert pin per byte, sampled with the data
// - write inversion and masking both off: pin receivers off, value ignored; training write still stores the pin pattern
// - read inversion off: pin drivers stay off for reads and mode reads
// - write inversion on: write or masked write byte inverted when the pin is sampled low, unless it is masked
// - read inversion: more than four ones inverts byte and drives pin high
// - masking on, write inversion off: plain write masks nothing, pin low
// - masked write, inversion off: pin high drops the bit time for the byte
// - masking and inversion on: pin low with five plus upper ones masks
// - training write treats the pin as pattern, no mask, no inversion
// - training read returns the pin pattern stored by training write
// - mode register read data never inverted; pin low if read inversion on
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"

module dbm_byte_mask_inversion
  import dbm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINK_STROBE,
  input wire logic [2:0] CMD_CODE,
  input wire logic [15:0] DQ_IN,
  output logic [15:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic [1:0] DMI_IN,
  output logic [1:0] DMI_OUT,
  output logic [1:0] DMI_OE_N,
  output logic WR_VALID,
  output logic [15:0] WR_DATA,
  output logic [1:0] WR_BYTE_EN,
  output logic [3:0] WR_BEAT,
  output logic [3:0] RD_BEAT,
  input wire logic [15:0] RD_DATA
);

  // ************************************************************
  // pin synchronisers and strobe edges
  // ************************************************************
  // limitation: each bit is synchronised alone, so the controller must
  // hold data and command steady around every strobe edge
  logic [21:0] sync_a;
  logic [21:0] sync_b;
  logic strobe_d;
  logic rise_s;
  logic edge_s;
  logic [15:0] s_dq;
  logic [1:0] s_dmi;
  dbm_cmd_t s_cmd;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sync_a <= 22'h0;
      sync_b <= 22'h0;
      strobe_d <= 1'b0;
    end else begin
      sync_a <= {LINK_STROBE, CMD_CODE, DMI_IN, DQ_IN};
      sync_b <= sync_a;
      strobe_d <= sync_b[21];
    end
  end

  assign rise_s = sync_b[21] & !strobe_d;
  assign edge_s = sync_b[21] ^ strobe_d;
  assign s_dq = sync_b[15:0];
  assign s_dmi = sync_b[17:16];
  assign s_cmd = dbm_cmd_t'(sync_b[20:18]);

  // ************************************************************
  // mode registers over APB
  // ************************************************************
  logic [7:0] mode_reg_io_config;
  logic [7:0] mode_reg_misc_control;
  logic illegal_mwr;
  logic apb_acc;
  logic apb_wr;
  logic addr_hit;
  logic wr_inv;
  logic rd_inv;
  logic mask_en;
  logic ill_set;
  dbm_state_t state;
  dbm_cmd_t cur_cmd;
  logic [4:0] beat;

  assign wr_inv = mode_reg_io_config[`DBM_WR_INV_BIT];
  assign rd_inv = mode_reg_io_config[`DBM_RD_INV_BIT];
  assign mask_en = !mode_reg_misc_control[`DBM_MASK_DIS_BIT];

  assign apb_acc = PSEL & PENABLE;
  assign addr_hit = (PADDR == `DBM_OFF_IO) | (PADDR == `DBM_OFF_MISC) | (PADDR == `DBM_OFF_STAT);
  assign apb_wr = apb_acc & PWRITE & addr_hit & PSTRB[0];
  assign PREADY = 1'b1;
  assign PSLVERR = apb_acc & !addr_hit;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mode_reg_io_config <= `DBM_IO_RST;
      mode_reg_misc_control <= `DBM_MISC_RST;
    end else if (apb_wr) begin
      if (PADDR == `DBM_OFF_IO) begin
        mode_reg_io_config <= PWDATA[7:0];
      end
      if (PADDR == `DBM_OFF_MISC) begin
        mode_reg_misc_control <= PWDATA[7:0];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      illegal_mwr <= 1'b0;
    end else if (ill_set) begin
      illegal_mwr <= 1'b1;
    end else if (apb_wr && PADDR == `DBM_OFF_STAT && PWDATA[`DBM_STAT_ILL_BIT]) begin
      illegal_mwr <= 1'b0;
    end
  end

  // read data is fetched in the setup phase so the access needs no wait
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `DBM_OFF_IO: PRDATA <= {24'h0, mode_reg_io_config};
        `DBM_OFF_MISC: PRDATA <= {24'h0, mode_reg_misc_control};
        `DBM_OFF_STAT: PRDATA <= {25'h0, cur_cmd, state, illegal_mwr};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  // ************************************************************
  // burst sequencing
  // ************************************************************
  logic is_rd;
  logic is_wr;
  logic take;
  logic cap;
  logic ld;
  logic rel;
  logic [3:0] idx;
  dbm_cmd_t eff_cmd;

  assign is_rd = (s_cmd == DBM_CMD_RD) | (s_cmd == DBM_CMD_MRR) | (s_cmd == DBM_CMD_FRD);
  assign is_wr = (s_cmd == DBM_CMD_WR) | (s_cmd == DBM_CMD_MWR) | (s_cmd == DBM_CMD_FWR);
  assign take = (state == DBM_ST_IDLE) & rise_s & (is_rd | is_wr);
  assign ill_set = take & (s_cmd == DBM_CMD_MWR) & !mask_en;
  assign cap = (state == DBM_ST_WR) & edge_s;
  assign ld = (take & is_rd) | ((state == DBM_ST_RD) & edge_s & (beat != `DBM_BEATS));
  assign rel = (state == DBM_ST_RD) & edge_s & (beat == `DBM_BEATS);
  assign idx = beat[3:0];
  assign eff_cmd = (state == DBM_ST_IDLE) ? s_cmd : cur_cmd;
  assign RD_BEAT = idx;

  // every burst, masked write included, is sixteen beats on both strobe edges
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state <= DBM_ST_IDLE;
      cur_cmd <= DBM_CMD_NONE;
      beat <= 5'h00;
    end else begin
      case (state)
        DBM_ST_IDLE: begin
          if (take) begin
            cur_cmd <= s_cmd;
            state <= is_rd ? DBM_ST_RD : DBM_ST_WR;
            beat <= is_rd ? 5'h01 : 5'h00;
          end
        end
        DBM_ST_WR: begin
          if (edge_s) begin
            if (idx == `DBM_LAST_BEAT) begin
              state <= DBM_ST_IDLE;
              beat <= 5'h00;
            end else begin
              beat <= beat + 5'h01;
            end
          end
        end
        DBM_ST_RD: begin
          if (rel) begin
            state <= DBM_ST_IDLE;
            beat <= 5'h00;
          end else if (edge_s) begin
            beat <= beat + 5'h01;
          end
        end
        default: begin
          state <= DBM_ST_IDLE;
          beat <= 5'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // byte lanes and training store
  // ************************************************************
  logic [15:0] fifo_dq [0:15];
  logic [1:0] fifo_dmi [0:15];
  logic [1:0] fifo_dmi_now;
  logic [15:0] rd_src;
  wire logic [15:0] lane_wr;
  wire logic [1:0] lane_keep;
  wire logic [15:0] lane_rd;
  wire logic [1:0] lane_dmi;
  wire logic [1:0] lane_drv;

  assign fifo_dmi_now = fifo_dmi[idx];
  assign rd_src = (eff_cmd == DBM_CMD_FRD) ? fifo_dq[idx] : RD_DATA;

  for (genvar g = 0; g < 2; g++) begin : g_lane
    dbm_lane u_lane (
      .cmd(eff_cmd),
      .wr_inv_en(wr_inv),
      .rd_inv_en(rd_inv),
      .mask_en(mask_en),
      .dq_in(s_dq[8*g +: 8]),
      .dmi_in(s_dmi[g]),
      .rd_raw(rd_src[8*g +: 8]),
      .fifo_dmi(fifo_dmi_now[g]),
      .wr_data(lane_wr[8*g +: 8]),
      .wr_keep(lane_keep[g]),
      .rd_data(lane_rd[8*g +: 8]),
      .rd_dmi(lane_dmi[g]),
      .rd_dmi_drive(lane_drv[g])
    );
  end

  // training write keeps the raw pin pattern and data for the training read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) begin
        fifo_dq[i] <= 16'h0;
        fifo_dmi[i] <= 2'h0;
      end
    end else if (cap && cur_cmd == DBM_CMD_FWR) begin
      fifo_dq[idx] <= s_dq;
      fifo_dmi[idx] <= s_dmi;
    end
  end

  // ************************************************************
  // core write port
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WR_VALID <= 1'b0;
      WR_DATA <= 16'h0;
      WR_BYTE_EN <= 2'h0;
      WR_BEAT <= 4'h0;
    end else begin
      WR_VALID <= cap & (cur_cmd != DBM_CMD_FWR);
      if (cap && cur_cmd != DBM_CMD_FWR) begin
        WR_DATA <= lane_wr;
        WR_BYTE_EN <= lane_keep;
        WR_BEAT <= idx;
      end
    end
  end

  // ************************************************************
  // link drive side
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      DQ_OUT <= 16'h0;
      DQ_OE_N <= 1'b1;
      DMI_OUT <= 2'h0;
      DMI_OE_N <= 2'h3;
    end else if (rel) begin
      DQ_OUT <= 16'h0;
      DQ_OE_N <= 1'b1;
      DMI_OUT <= 2'h0;
      DMI_OE_N <= 2'h3;
    end else if (ld) begin
      DQ_OUT <= lane_rd;
      DQ_OE_N <= 1'b0;
      DMI_OUT <= lane_dmi & lane_drv;
      DMI_OE_N <= ~lane_drv;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_rd_drivers_off: assert property (
    ld && (eff_cmd == DBM_CMD_RD || eff_cmd == DBM_CMD_MRR) && !rd_inv |=> DMI_OE_N == 2'h3)
    else $error("mask pin driven with read inversion off");
  a_mrr_pin_low: assert property (
    ld && eff_cmd == DBM_CMD_MRR |=> DMI_OUT == 2'h0 && DQ_OUT == $past(RD_DATA))
    else $error("mode read data altered or pin not low");
  a_rd_invert_ones: assert property (
    ld && eff_cmd == DBM_CMD_RD && rd_inv |=> DMI_OUT[0] == ($countones($past(RD_DATA[7:0])) > 4)
      && DQ_OUT[7:0] == ($past(RD_DATA[7:0]) ^ {8{DMI_OUT[0]}}))
    else $error("read inversion wrong on lower lane");
  a_plain_no_mask: assert property (
    cap && cur_cmd == DBM_CMD_WR |=> WR_VALID && WR_BYTE_EN == 2'h3)
    else $error("plain write masked a byte");
  a_wr_invert_low: assert property (
    cap && cur_cmd == DBM_CMD_WR && wr_inv |=> WR_DATA[15:8] == ($past(s_dq[15:8]) ^ {8{!$past(s_dmi[1])}}))
    else $error("write inversion wrong on upper lane");
  a_mask_pin_high: assert property (
    cap && cur_cmd == DBM_CMD_MWR && mask_en && !wr_inv |=> WR_BYTE_EN == ~$past(s_dmi))
    else $error("mask does not follow pin");
  a_mask_dbi_five: assert property (
    cap && cur_cmd == DBM_CMD_MWR && mask_en && wr_inv && !s_dmi[0] && $countones(s_dq[7:2]) >= 5
      |=> !WR_BYTE_EN[0])
    else $error("five-ones pattern not masked");
  a_rx_pin_off: assert property (
    cap && cur_cmd == DBM_CMD_WR && !wr_inv && !mask_en |=> WR_DATA == $past(s_dq) && WR_BYTE_EN == 2'h3)
    else $error("pin value used with receivers off");
  a_fifo_wr_quiet: assert property (
    cap && cur_cmd == DBM_CMD_FWR |=> !WR_VALID)
    else $error("training write reached the array");
  a_fifo_rd_pattern: assert property (
    ld && eff_cmd == DBM_CMD_FRD |=> DMI_OE_N == 2'h0 && DMI_OUT == $past(fifo_dmi_now))
    else $error("training read pattern wrong");
  a_burst_sixteen: assert property (
    cap && idx == `DBM_LAST_BEAT |=> state == DBM_ST_IDLE ##1 !WR_VALID)
    else $error("write burst not closed after sixteen beats");

  c_masked_write: cover property (cap && cur_cmd == DBM_CMD_MWR && mask_en);
  c_read_inverted: cover property (ld && eff_cmd == DBM_CMD_RD ##1 DMI_OUT != 2'h0);
  c_fifo_read: cover property (ld && eff_cmd == DBM_CMD_FRD);
  c_apb_error: cover property (PSLVERR);
endmodule // dbm_byte_mask_inversion

`default_nettype wire

//--- dbm_defines.svh
// dbm_defines.svh: register offsets, field positions, reset values and burst counts
// assumes: included by its bare name by the block module, the lane and the bench of the byte mask / inversion block
`ifndef DBM_DEFINES_SVH
`define DBM_DEFINES_SVH

// ************************************************************
// register offsets (byte addresses on the APB side)
// ************************************************************
`define DBM_OFF_IO 8'h00
`define DBM_OFF_MISC 8'h04
`define DBM_OFF_STAT 8'h08

// ************************************************************
// field positions and reset values
// ************************************************************
`define DBM_WR_INV_BIT 7
`define DBM_RD_INV_BIT 6
`define DBM_MASK_DIS_BIT 5
`define DBM_IO_RST 8'h00
`define DBM_MISC_RST 8'h20
`define DBM_STAT_ILL_BIT 0

// ************************************************************
// burst and symbol counts
// ************************************************************
`define DBM_BEATS 5'h10
`define DBM_LAST_BEAT 4'hF
`define DBM_RD_ONES_MAX 4'h4
`define DBM_MW_ONES_MIN 3'h5

`endif

//--- dbm_pkg.sv
// dbm_pkg.sv: types of the byte mask / inversion block
// assumes: compiled before every module of the block
package dbm_pkg;
  // command code on the link command pins
  typedef enum logic [2:0] {
    DBM_CMD_NONE = 3'h0,
    DBM_CMD_WR = 3'h1,
    DBM_CMD_MWR = 3'h2,
    DBM_CMD_RD = 3'h3,
    DBM_CMD_MRR = 3'h4,
    DBM_CMD_FWR = 3'h5,
    DBM_CMD_FRD = 3'h6
  } dbm_cmd_t;
  typedef enum logic [2:0] {
    DBM_ST_IDLE = 3'h1,
    DBM_ST_WR = 3'h2,
    DBM_ST_RD = 3'h4
  } dbm_state_t;
endpackage

//--- dbm_lane.sv
// dbm_lane.sv: one byte lane, decides invert / mask / pass for one bit time
// assumes: purely combinational; the parent registers everything it drives out
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"

module dbm_lane
  import dbm_pkg::*;
(
  input wire dbm_cmd_t cmd,
  input wire logic wr_inv_en,
  input wire logic rd_inv_en,
  input wire logic mask_en,
  input wire logic [7:0] dq_in,
  input wire logic dmi_in,
  input wire logic [7:0] rd_raw,
  input wire logic fifo_dmi,
  output logic [7:0] wr_data,
  output logic wr_keep,
  output logic [7:0] rd_data,
  output logic rd_dmi,
  output logic rd_dmi_drive
);
  logic dmi_rx;
  logic [3:0] rd_ones;
  logic [2:0] hi_ones;

  // receiver off: the pin reads as low whatever the controller drives
  assign dmi_rx = (wr_inv_en | mask_en) & dmi_in;

  always_comb begin
    rd_ones = 4'h0;
    hi_ones = 3'h0;
    for (int i = 0; i < 8; i++) begin
      rd_ones = rd_ones + {3'h0, rd_raw[i]};
    end
    for (int i = 2; i < 8; i++) begin
      hi_ones = hi_ones + {2'h0, dq_in[i]};
    end
  end

  // ************************************************************
  // write direction
  // ************************************************************
  always_comb begin
    wr_data = dq_in;
    wr_keep = 1'b1;
    case (cmd)
      DBM_CMD_WR: begin
        // plain write never masks, even with masking on
        if (wr_inv_en && !dmi_rx) begin
          wr_data = ~dq_in;
        end
      end
      DBM_CMD_MWR: begin
        if (!mask_en) begin
          // illegal here; handled like a plain write so nothing is lost
          if (wr_inv_en && !dmi_rx) begin
            wr_data = ~dq_in;
          end
        end else if (!wr_inv_en) begin
          wr_keep = !dmi_rx;
        end else if (!dmi_rx && hi_ones >= `DBM_MW_ONES_MIN) begin
          wr_keep = 1'b0;
        end else if (!dmi_rx) begin
          wr_data = ~dq_in;
        end
      end
      default: begin
        // training write and idle pass the data untouched
        wr_keep = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // read direction
  // ************************************************************
  always_comb begin
    rd_data = rd_raw;
    rd_dmi = 1'b0;
    rd_dmi_drive = 1'b0;
    case (cmd)
      DBM_CMD_RD: begin
        rd_dmi_drive = rd_inv_en;
        if (rd_inv_en && rd_ones > `DBM_RD_ONES_MAX) begin
          rd_data = ~rd_raw;
          rd_dmi = 1'b1;
        end
      end
      DBM_CMD_MRR: begin
        // pin held low, data never inverted
        rd_dmi_drive = rd_inv_en;
      end
      DBM_CMD_FRD: begin
        rd_dmi_drive = 1'b1;
        rd_dmi = fifo_dmi;
      end
      default: begin
        rd_dmi_drive = 1'b0;
      end
    endcase
  end
endmodule // dbm_lane

`default_nettype wire

//--- dbm_ctrl_model.sv
// dbm_ctrl_model.sv: behavioural memory controller on the link side of the block
// assumes: bursts are started by task calls from the bench; strobe edges sit off SYS_CLK edges
`timescale 1ns/1ps
`default_nettype none

module dbm_ctrl_model
  import dbm_pkg::*;
(
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [1:0] dmi_out,
  input wire logic [1:0] dmi_oe_n,
  output var logic strobe,
  output var logic [2:0] cmd,
  output logic [15:0] dq_in,
  output logic [1:0] dmi_in
);
  logic [15:0] dq = 16'h0000;
  logic [1:0] mask_invert_pin = 2'h0;
  logic drv = 1'b0;
  logic [15:0] rq [16];
  logic [1:0] rm [16];
  logic [2:0] ro [16];

  initial begin
    strobe = 1'b0;
    cmd = DBM_CMD_NONE;
  end

  // a released line shows the inverse of its last value so stale data never passes as good
  assign dq_in = dq_oe_n ? (drv ? dq : ~dq) : dq_out;
  assign dmi_in = (dmi_oe_n & (drv ? mask_invert_pin : ~mask_invert_pin)) | (~dmi_oe_n & dmi_out);

  function automatic logic [15:0] pat(input logic [3:0] k);
    return {8'hFF >> k[2:0], 8'hFF << k[2:0]};
  endfunction

  function automatic logic [1:0] dmip(input logic [3:0] k);
    return {k[0], k[1]};
  endfunction

  // command on the first rising edge, sixteen beat edges, then one edge back to idle low
  task automatic burst(input dbm_cmd_t c, input logic lo);
    int k;
    begin
      cmd = c;
      drv = (c == DBM_CMD_WR) || (c == DBM_CMD_MWR) || (c == DBM_CMD_FWR);
      #107 strobe = 1'b1;
      for (k = 0; k < 17; k++) begin
        #50;
        cmd = DBM_CMD_NONE;
        if (k < 16) begin
          dq = pat(k[3:0]);
          mask_invert_pin = lo ? 2'b00 : dmip(k[3:0]);
        end else begin
          drv = 1'b0;
        end
        #50;
        // read beat k only stands about three clocks after its edge, so sample just before the next edge
        if (k < 16) begin
          rq[k] = dq_in;
          rm[k] = dmi_in;
          ro[k] = {dq_oe_n, dmi_oe_n};
        end
        strobe = ~strobe;
      end
      #200;
    end
  endtask
endmodule // dbm_ctrl_model

`default_nettype wire

//--- dbm_byte_mask_inversion_tb_top.sv
// dbm_byte_mask_inversion_tb_top.sv: self-checking bench of the mask / inversion block
// assumes: dbm_pkg and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"

module dbm_byte_mask_inversion_tb_top
  import dbm_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'hF;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, LINK_STROBE, DQ_OE_N, WR_VALID;
  logic [2:0] CMD_CODE;
  logic [15:0] DQ_IN, DQ_OUT, WR_DATA, RD_DATA;
  logic [1:0] DMI_IN, DMI_OUT, DMI_OE_N, WR_BYTE_EN;
  logic [3:0] WR_BEAT, RD_BEAT;
  int err_total = 0;
  int total_checks = 0;
  int wn = 0;
  int cyc = 0;
  logic [7:0] io_s = `DBM_IO_RST;
  logic [7:0] misc_s = `DBM_MISC_RST;
  logic [15:0] wd [16];
  logic [1:0] we [16];
  logic [31:0] rdat;
  logic rerr;

  always #12.5 SYS_CLK = ~SYS_CLK;

  dbm_byte_mask_inversion dbm_byte_mask_inversion_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_STROBE(LINK_STROBE), .CMD_CODE(CMD_CODE), .DQ_IN(DQ_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .DMI_IN(DMI_IN), .DMI_OUT(DMI_OUT), .DMI_OE_N(DMI_OE_N),
    .WR_VALID(WR_VALID), .WR_DATA(WR_DATA), .WR_BYTE_EN(WR_BYTE_EN), .WR_BEAT(WR_BEAT), .RD_BEAT(RD_BEAT),
    .RD_DATA(RD_DATA));

  dbm_ctrl_model dbm_ctrl_model_inst (.dq_out(DQ_OUT), .dq_oe_n(DQ_OE_N), .dmi_out(DMI_OUT),
    .dmi_oe_n(DMI_OE_N), .strobe(LINK_STROBE), .cmd(CMD_CODE), .dq_in(DQ_IN), .dmi_in(DMI_IN));

  // core side answers each read beat from the same pattern the controller writes
  assign RD_DATA = dbm_ctrl_model_inst.pat(RD_BEAT);

  always @(posedge SYS_CLK) begin
    if (WR_VALID === 1'b1) begin
      wd[WR_BEAT] = WR_DATA;
      we[WR_BEAT] = WR_BYTE_EN;
      wn++;
    end
  end

  // ************************************************************
  // checking and closing
  // ************************************************************
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // a run of bursts takes about 1100 cycles, so this ceiling only catches a hang
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      conclude();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp) begin
        err_total++;
        $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // ************************************************************
  // bus and burst tasks
  // ************************************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      @(posedge SYS_CLK);
      while (PREADY !== 1'b1) @(posedge SYS_CLK);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    begin
      apb(1'b0, a, 32'h0);
      check(rdat & mask, exp);
      check({31'h0, rerr}, {31'h0, a > `DBM_OFF_STAT});
    end
  endtask

  task cfg(input logic [7:0] io, input logic [7:0] misc);
    begin
      io_s = io;
      misc_s = misc;
      apb(1'b1, `DBM_OFF_IO, {24'h0, io});
      apb(1'b1, `DBM_OFF_MISC, {24'h0, misc});
    end
  endtask

  function automatic logic [17:0] exp_w(input dbm_cmd_t c, input logic [3:0] k, input logic lo);
    logic [15:0] d;
    logic [1:0] m;
    logic [17:0] r;
    int i;
    begin
      d = dbm_ctrl_model_inst.pat(k);
      m = lo ? 2'b00 : dbm_ctrl_model_inst.dmip(k);
      for (i = 0; i < 2; i++) begin
        r[16+i] = 1'b1;
        r[i*8+:8] = (io_s[7] && !m[i]) ? ~d[i*8+:8] : d[i*8+:8];
        if (c == DBM_CMD_MWR && !misc_s[5]) begin
          if (!io_s[7]) r[16+i] = ~m[i];
          else if (!m[i] && $countones(d[i*8+2+:6]) >= `DBM_MW_ONES_MIN) r[16+i] = 1'b0;
        end
      end
      return r;
    end
  endfunction

  function automatic logic [20:0] exp_r(input dbm_cmd_t c, input logic [3:0] k);
    logic [15:0] d;
    logic [1:0] m;
    int i;
    begin
      d = dbm_ctrl_model_inst.pat(k);
      m = 2'b00;
      for (i = 0; i < 2; i++) begin
        if (c == DBM_CMD_RD && io_s[6] && $countones(d[i*8+:8]) > `DBM_RD_ONES_MAX) begin
          d[i*8+:8] = ~d[i*8+:8];
          m[i] = 1'b1;
        end
      end
      if (c == DBM_CMD_FRD) return {3'b000, dbm_ctrl_model_inst.dmip(k), d};
      return {1'b0, {2{~io_s[6]}}, m, d};
    end
  endfunction

  task automatic wtest(input dbm_cmd_t c, input logic lo);
    int k;
    logic [17:0] e;
    logic [15:0] bm;
    begin
      wn = 0;
      dbm_ctrl_model_inst.burst(c, lo);
      check(32'(wn), (c == DBM_CMD_FWR) ? 32'h0 : 32'h10);
      for (k = 0; k < 16 && c != DBM_CMD_FWR; k++) begin
        e = exp_w(c, k[3:0], lo);
        bm = {{8{e[17]}}, {8{e[16]}}};
        check({14'h0, we[k], wd[k] & bm}, {14'h0, e[17:16], e[15:0] & bm});
      end
      $display("write burst test done, command %0d", c);
    end
  endtask

  task automatic rtest(input dbm_cmd_t c);
    int k;
    logic [20:0] e;
    begin
      dbm_ctrl_model_inst.burst(c, 1'b0);
      for (k = 0; k < 16; k++) begin
        e = exp_r(c, k[3:0]);
        check({11'h0, dbm_ctrl_model_inst.ro[k], dbm_ctrl_model_inst.rm[k] & ~e[19:18],
          dbm_ctrl_model_inst.rq[k]}, {11'h0, e[20:18], e[17:16] & ~e[19:18], e[15:0]});
      end
      check({29'h0, DQ_OE_N, DMI_OE_N}, 32'h7);
      $display("read burst test done, command %0d", c);
    end
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rchk(`DBM_OFF_IO, {24'h0, `DBM_IO_RST}, 32'h000000FF);
    rchk(`DBM_OFF_MISC, {24'h0, `DBM_MISC_RST}, 32'h000000FF);
    rchk(8'h0C, 32'h0, 32'hFFFFFFFF);
    wtest(DBM_CMD_WR, 1'b0);
    wtest(DBM_CMD_MWR, 1'b0);
    rchk(`DBM_OFF_STAT, 32'h23, 32'h7F);
    apb(1'b1, `DBM_OFF_STAT, 32'h1);
    rchk(`DBM_OFF_STAT, 32'h22, 32'h7F);
    rtest(DBM_CMD_RD);
    rtest(DBM_CMD_MRR);
    cfg(8'h80, 8'h20);
    wtest(DBM_CMD_WR, 1'b0);
    cfg(8'h00, 8'h00);
    wtest(DBM_CMD_WR, 1'b1);
    wtest(DBM_CMD_MWR, 1'b0);
    cfg(8'h80, 8'h00);
    wtest(DBM_CMD_MWR, 1'b0);
    wtest(DBM_CMD_WR, 1'b0);
    cfg(8'h40, 8'h20);
    rtest(DBM_CMD_RD);
    rtest(DBM_CMD_MRR);
    wtest(DBM_CMD_FWR, 1'b0);
    rtest(DBM_CMD_FRD);
    @(posedge SYS_CLK);
    PSTRB <= 4'h0;
    apb(1'b1, `DBM_OFF_IO, 32'h000000FF);
    PSTRB <= 4'hF;
    rchk(`DBM_OFF_IO, 32'h40, 32'h000000FF);
    conclude();
  end
endmodule // dbm_byte_mask_inversion_tb_top

`default_nettype wire
